// ===== dio_port.v
// Digital input/output port with delay filters, edge interrupts and APB registers
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "dio_port_defs.vh"

module dio_port (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] field_input_line,
  output reg  [11:0] field_output_line,
  input  wire        output_overload,
  input  wire        sensor_supply_error,
  output reg  [15:0] input_state_led,
  output reg         output_overload_fault_led,
  output reg         sensor_supply_fault_led,
  output reg         irq
);

  // Delay limit in ticks for one channel
  function [`DLY_W-1:0] dly_limit;
    input [1:0] sel;
    input       fast;
    begin
      case (sel)
        `SEL_SHORT: dly_limit = fast ? `DLY_SHORT_TICKS : `DLY_HALF_TICKS;
        `SEL_HALF:  dly_limit = `DLY_HALF_TICKS;
        `SEL_MID:   dly_limit = `DLY_MID_TICKS;
        `SEL_LONG:  dly_limit = `DLY_LONG_TICKS;
        default:    dly_limit = `DLY_LONG_TICKS;
      endcase
    end
  endfunction

  // Register address match, used for the write decode only; reads decode paddr in a case
  function is_addr;
    input [11:0] a;
    input [11:0] ref_a;
    begin
      is_addr = (a == ref_a);
    end
  endfunction

  localparam [15:0] FAST = `FAST_MASK;

  reg  [`TICK_CNT_W-1:0] tick_cnt_r;
  reg                    tick_r;
  reg  [15:0]            in_smp_r;
  wire [15:0]            filt;
  reg  [15:0]            filt_d_r;
  reg  [15:0]            rise_en_r;
  reg  [15:0]            fall_en_r;
  reg  [7:0]             delay_r;
  reg  [`STAT_W-1:0]     status_r;
  reg  [`STAT_W-1:0]     status_nxt;
  reg  [`STAT_W-1:0]     enable_r;
  reg  [11:0]            out_r;
  wire                   setup;
  wire                   wr;
  wire [15:0]            edge_hit;
  wire                   lost;
  wire [`STAT_W-1:0]     clr;
  reg  [31:0]            rd_nxt;
  reg                    err_nxt;

  // 0.1 ms tick from the 10 MHz clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 10'h000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == `TICK_LAST) begin
      tick_cnt_r <= 10'h000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 10'h001;
      tick_r     <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_smp_r <= 16'h0000;
    end else begin
      in_smp_r <= field_input_line;
    end
  end

  // One filter per channel; the group of four shares a delay field
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_ch
      reg [`DLY_W-1:0] lim_r;

      // Registered limit keeps the delay decode out of the counter path
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          // Matches the reset delay select of zero
          lim_r <= FAST[g] ? `DLY_SHORT_TICKS : `DLY_HALF_TICKS;
        end else begin
          lim_r <= dly_limit(delay_r[2*(g/4)+1 -: 2], FAST[g]);
        end
      end

      input_filter_cell u_filt (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick_r),
        .raw   (in_smp_r[g]),
        .limit (lim_r),
        .filt  (filt[g])
      );
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_d_r <= 16'h0000;
    end else begin
      filt_d_r <= filt;
    end
  end

  // Edges taken after the filter so glitches never reach the status
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_evt
      wire rise_w;
      wire fall_w;

      assign rise_w      = filt[g] & ~filt_d_r[g];
      assign fall_w      = ~filt[g] & filt_d_r[g];
      // No selected edge, no event
      assign edge_hit[g] = (rise_w & rise_en_r[g]) | (fall_w & fall_en_r[g]);
    end
  endgenerate

  // An edge on a channel whose event is still pending is lost
  assign lost = |(edge_hit & status_r[15:0]);

  // APB: answer in the first access cycle, no wait states
  assign setup = psel & ~penable & ~pready;
  assign wr    = psel & penable & pready & pwrite;
  assign clr   = (wr && is_addr(paddr, `ADDR_CLEAR)) ? pwdata[`STAT_W-1:0] : 17'h00000;

  // Read word for the addressed place; write-only places read zero
  always @* begin
    rd_nxt  = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
      `ADDR_IO_LOW: begin
        rd_nxt[7:0] = pwrite ? 8'h00 : filt[7:0];
      end
      `ADDR_IO_HIGH: begin
        rd_nxt[7:0] = pwrite ? 8'h00 : filt[15:8];
      end
      `ADDR_RISE_EN: begin
        rd_nxt[15:0] = rise_en_r;
      end
      `ADDR_FALL_EN: begin
        rd_nxt[15:0] = fall_en_r;
      end
      `ADDR_DELAY: begin
        rd_nxt[7:0] = delay_r;
      end
      `ADDR_STATUS: begin
        rd_nxt[`STAT_W-1:0] = status_r;
      end
      `ADDR_CLEAR: begin
        rd_nxt = 32'h00000000;
      end
      `ADDR_ENABLE: begin
        rd_nxt[`STAT_W-1:0] = enable_r;
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= err_nxt;
      prdata  <= rd_nxt;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software-written configuration and output image
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_en_r <= 16'h0000;
      fall_en_r <= 16'h0000;
      delay_r   <= `RST_DELAY;
      enable_r  <= 17'h00000;
      out_r     <= 12'h000;
    end else if (wr) begin
      if (is_addr(paddr, `ADDR_RISE_EN)) begin
        rise_en_r <= pwdata[15:0];
      end
      if (is_addr(paddr, `ADDR_FALL_EN)) begin
        fall_en_r <= pwdata[15:0];
      end
      if (is_addr(paddr, `ADDR_DELAY)) begin
        delay_r <= pwdata[7:0];
      end
      if (is_addr(paddr, `ADDR_ENABLE)) begin
        enable_r <= pwdata[`STAT_W-1:0];
      end
      if (is_addr(paddr, `ADDR_IO_LOW)) begin
        out_r[7:0] <= pwdata[7:0];
      end
      if (is_addr(paddr, `ADDR_IO_HIGH)) begin
        out_r[11:8] <= pwdata[3:0];
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always @* begin
    status_nxt = status_r & ~clr;
    status_nxt[15:0] = status_nxt[15:0] | edge_hit;
    status_nxt[`LOST_BIT] = status_nxt[`LOST_BIT] | lost;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 17'h00000;
      irq      <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq      <= |(status_nxt & enable_r);
    end
  end

  // Pins and lamps, all registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      field_output_line         <= 12'h000;
      input_state_led           <= 16'h0000;
      output_overload_fault_led <= 1'b0;
      sensor_supply_fault_led   <= 1'b0;
    end else begin
      field_output_line         <= out_r;
      input_state_led           <= filt;
      output_overload_fault_led <= output_overload;
      sensor_supply_fault_led   <= sensor_supply_error;
    end
  end

endmodule // dio_port
`default_nettype wire

// ===== dio_port_defs.vh
// Constants for the digital input/output port with edge interrupts
`ifndef DIO_PORT_DEFS_VH
`define DIO_PORT_DEFS_VH

`define CLK_PERIOD_NS   100
`define TICK_NS         100000
`define TICK_CYC        (`TICK_NS / `CLK_PERIOD_NS)
`define TICK_LAST       10'h3E7
`define TICK_CNT_W      10

`define DLY_W           8
`define DLY_SHORT_US    100
`define DLY_HALF_US     500
`define DLY_MID_US      3000
`define DLY_LONG_US     15000
// Filter limits in 0.1 ms ticks, sized to the counter
`define DLY_SHORT_TICKS 8'h01
`define DLY_HALF_TICKS  8'h05
`define DLY_MID_TICKS   8'h1E
`define DLY_LONG_TICKS  8'h96

`define SEL_SHORT       2'h0
`define SEL_HALF        2'h1
`define SEL_MID         2'h2
`define SEL_LONG        2'h3

`define FAST_MASK       16'h8ED8

`define IDX_IO_LOW      10'h088
`define IDX_IO_HIGH     10'h089
`define ADDR_IO_LOW     ({`IDX_IO_LOW, 2'h0})
`define ADDR_IO_HIGH    ({`IDX_IO_HIGH, 2'h0})
`define ADDR_RISE_EN    12'h000
`define ADDR_FALL_EN    12'h004
`define ADDR_DELAY      12'h008
`define ADDR_STATUS     12'h00C
`define ADDR_CLEAR      12'h010
`define ADDR_ENABLE     12'h014

`define LOST_BIT        16
`define STAT_W          17
`define RST_DELAY       8'h00

`endif

// ===== input_filter_cell.v
// One channel of the input delay filter
`timescale 1ns/100ps
`default_nettype none
`include "dio_port_defs.vh"

module input_filter_cell (
  input  wire               clk,
  input  wire               rst_n,
  input  wire               tick,
  input  wire               raw,
  input  wire [`DLY_W-1:0]  limit,
  output reg                filt
);

  reg [`DLY_W-1:0] cnt_r;

  // Stable-time counter; any return to the old level restarts it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      filt  <= 1'b0;
    end else if (raw == filt) begin
      cnt_r <= 8'h00;
    end else if (tick) begin
      if (cnt_r + 8'h01 >= limit) begin
        cnt_r <= 8'h00;
        filt  <= raw;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

endmodule // input_filter_cell
`default_nettype wire

// ===== dio_port_props.sv
// Port-level checker for the digital input/output port
`timescale 1ns/100ps
`default_nettype none
`include "dio_port_defs.vh"
module dio_port_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [11:0] field_output_line,
  input wire logic        output_overload,
  input wire logic        sensor_supply_error,
  input wire logic [15:0] input_state_led,
  input wire logic        output_overload_fault_led,
  input wire logic        sensor_supply_fault_led,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Writes land and reads are taken on the access edge only
  wire wr = psel & penable & pready & pwrite;
  wire rdc = psel & penable & pready & !pwrite;
  wire wreq = psel & pwrite;
  out_low_a: assert property (
    wr && paddr == `ADDR_IO_LOW |-> ##2 field_output_line[7:0] == $past(pwdata[7:0], 2)
  ) else $error("low output byte not applied");
  out_high_a: assert property (
    wr && paddr == `ADDR_IO_HIGH |-> ##2 field_output_line[11:8] == $past(pwdata[3:0], 2)
  ) else $error("high output nibble not applied");
  in_low_a: assert property (
    rdc && paddr == `ADDR_IO_LOW && $stable(input_state_led)
    |-> prdata == {24'h0, input_state_led[7:0]}
  ) else $error("low input byte wrong");
  in_high_a: assert property (
    rdc && paddr == `ADDR_IO_HIGH && $stable(input_state_led)
    |-> prdata == {24'h0, input_state_led[15:8]}
  ) else $error("high input byte wrong");
  ovl_lamp_a: assert property (
    $past(rst_n) |-> output_overload_fault_led == $past(output_overload)
  ) else $error("overload lamp wrong");
  supply_lamp_a: assert property (
    $past(rst_n) |-> sensor_supply_fault_led == $past(sensor_supply_error)
  ) else $error("supply lamp wrong");
  irq_quiet_a: assert property (
    $rose(rst_n) |-> !irq ##1 !irq
  ) else $error("interrupt right after reset");
  // Interrupt moves only on an input edge or a register write
  irq_cause_a: assert property (
    $changed(irq) |-> $changed(input_state_led) || $past(wreq)
      || $past(wreq, 2)
  ) else $error("interrupt changed without cause");
endmodule // dio_port_props
bind dio_port dio_port_props props (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .field_output_line, .output_overload, .sensor_supply_error,
  .input_state_led, .output_overload_fault_led, .sensor_supply_fault_led, .irq);
`default_nettype wire

// ===== field_model.sv
// Field side: sensors on the inputs, actuators that may short
`timescale 1ns/100ps
`default_nettype none
module field_model (
  input  wire logic [0:0]  clk,
  input  wire logic [15:0] level,
  input  wire logic [11:0] short_mask,
  input  wire logic [11:0] field_output_line,
  output var  logic [15:0] field_input_line = 16'h0,
  output var  logic        output_overload = 1'h0
);
  // Contacts switch cleanly after an edge; a shorted actuator trips only while driven
  always @(posedge clk) begin
    field_input_line <= level;
    output_overload  <= |(field_output_line & short_mask);
  end
endmodule // field_model
`default_nettype wire

// ===== dio_port_bench.sv
// Self-checking bench for the digital input/output port
`timescale 1ns/100ps
`default_nettype none
`include "dio_port_defs.vh"
module dio_port_bench;
  logic        clk, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic        irq, sensor_supply_error = 0, output_overload, output_overload_fault_led;
  logic        sensor_supply_fault_led;
  logic [11:0] paddr = 0, field_output_line, short_mask = 0;
  logic [15:0] level = 0, field_input_line, input_state_led;
  logic [31:0] pwdata = 0, prdata, rd;
  int          bad_count = 0, check_count = 0;
  dio_port uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .field_input_line, .field_output_line, .output_overload, .sensor_supply_error,
    .input_state_led, .output_overload_fault_led, .sensor_supply_fault_led, .irq);
  field_model fm (.clk, .level, .short_mask, .field_output_line, .field_input_line,
    .output_overload);
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic finish_test;
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Idle edge first, so psel never drops and rises in one time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk("read", rd, e);
  endtask
  initial begin
    cyc(16);
    rst_n <= 1'h1;
    for (int i = 0; i < 6; i++) rchk(12'(i * 4), 32'h0);
    apb(1'h0, 12'h100, 32'h0);
    chk("slverr", err, 32'h1);
    apb(1'h1, `ADDR_IO_LOW, 32'hA5);
    apb(1'h1, `ADDR_IO_HIGH, 32'hF3);
    cyc(3);
    chk("outputs", field_output_line, 32'h3A5);
    short_mask <= 12'h004;
    sensor_supply_error <= 1'h1;
    cyc(4);
    chk("ovl", output_overload_fault_led, 32'h1);
    chk("supply", sensor_supply_fault_led, 32'h1);
    short_mask <= 12'h0;
    sensor_supply_error <= 1'h0;
    cyc(4);
    chk("lamps", {output_overload_fault_led, sensor_supply_fault_led}, 32'h0);
    apb(1'h1, `ADDR_RISE_EN, 32'h28);
    apb(1'h1, `ADDR_FALL_EN, 32'h8);
    apb(1'h1, `ADDR_ENABLE, 32'h1FFFF);
    // Slow input 5 pulses for two ticks only, far below its 0.5 ms filter
    level <= 16'h0020;
    cyc(2000);
    level <= 16'h0008;
    cyc(2500);
    chk("led", input_state_led, 32'h8);
    chk("irq", irq, 32'h1);
    rchk(`ADDR_STATUS, 32'h8);
    rchk(`ADDR_IO_LOW, 32'h8);
    level <= 16'h0;
    cyc(2500);
    rchk(`ADDR_STATUS, 32'h10008);
    apb(1'h1, `ADDR_ENABLE, 32'h0);
    cyc(3);
    chk("masked", irq, 32'h0);
    apb(1'h1, `ADDR_CLEAR, 32'h1FFFF);
    apb(1'h1, `ADDR_RISE_EN, 32'h0);
    level <= 16'h0008;
    cyc(2500);
    rchk(`ADDR_STATUS, 32'h0);
    level <= 16'h0;
    cyc(2500);
    rchk(`ADDR_STATUS, 32'h8);
    // Groups 0..3 select 0.1 (0.5 on slow channels), 0.5, 15 and 3 ms
    apb(1'h1, `ADDR_DELAY, 32'hB4);
    level <= 16'h9331;
    cyc(3000);
    chk("slow", input_state_led, 32'h0);
    cyc(4000);
    chk("group0", input_state_led, 32'h31);
    cyc(20000);
    chk("group3", input_state_led, 32'h31);
    cyc(5000);
    chk("group3", input_state_led, 32'h9031);
    finish_test;
  end
  initial begin
    #10_000_000;
    bad_count++;
    finish_test;
  end
endmodule // dio_port_bench
`default_nettype wire
